// File: src/sync_rx_csr_pkg.sv
// shared constants and carriers for the synchronous sync_receive_control_status bank
package sync_rx_csr_pkg;

  // ---------------------------------------------------------------
  // register byte offsets from the interface base
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_IND_SEL   = 4'h0;
  localparam logic [3:0] OFS_IND_DATA  = 4'h2;
  localparam logic [3:0] OFS_RX_CSR    = 4'h4;
  localparam logic [3:0] OFS_TX_CSR    = 4'h6;
  localparam logic [3:0] OFS_PRI_COUNT = 4'h8;

  // indirect register index of the receiver error register
  localparam logic [3:0] IND_RX_ERR = 4'h1;

  // ---------------------------------------------------------------
  // sync_receive_control_status field positions
  // ---------------------------------------------------------------
  localparam int unsigned RX_DONE_PRI_BIT = 15;
  localparam int unsigned RX_ERR_BIT      = 14;
  localparam int unsigned RX_ROLE_BIT     = 13;
  localparam int unsigned RX_LOOP_BIT     = 8;
  localparam int unsigned RX_IE_BIT       = 6;
  localparam int unsigned RX_EN_BIT       = 4;

  // software-writable sync_receive_control_status bits: role, loop, low byte
  localparam logic [15:0] RX_RW_MASK = 16'h21FF;

  // ---------------------------------------------------------------
  // reset values and widths
  // ---------------------------------------------------------------
  localparam logic [15:0] RX_CSR_RST    = 16'h8000;
  localparam logic [15:0] TX_CSR_RST    = 16'h0000;
  localparam logic [13:0] PRI_COUNT_RST = 14'h0000;
  localparam logic [7:0]  RX_ERR_RST    = 8'h00;
  localparam logic [3:0]  IND_SEL_RST   = 4'h0;
  localparam int unsigned PRI_COUNT_W   = 14;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  addr;
    logic        rd;
    logic        wr;
    logic        byte_acc;
    logic [15:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic data;
    logic clk_en;
  } serial_t;

endpackage

// File: src/rx_error_bank.sv
// receiver error register with its or-summary and rising-edge event
`timescale 1ns/1ps
module rx_error_bank (
  // clock and clear
  input  wire logic       i_sys_clk,
  input  wire logic       i_clear,
  // error events and read clear
  input  wire logic [7:0] i_err_set,
  input  wire logic       i_rd_clear,
  // state
  output logic [7:0]      o_err_q,
  output logic            o_summary,
  output logic            o_summary_rise
);

  logic summary_prev_q;

  // sticky flags; a new error in the read cycle survives the clear
  always_ff @(posedge i_sys_clk) begin
    if (i_clear) begin
      o_err_q <= sync_rx_csr_pkg::RX_ERR_RST;
    end else begin
      o_err_q <= (o_err_q & {8{~i_rd_clear}}) | i_err_set;
    end
  end

  // previous summary, for the one-cycle set event
  always_ff @(posedge i_sys_clk) begin
    if (i_clear) begin
      summary_prev_q <= 1'b0;
    end else begin
      summary_prev_q <= o_summary;
    end
  end

  assign o_summary      = |o_err_q;
  assign o_summary_rise = o_summary & ~summary_prev_q;

endmodule

// File: src/loop_router.sv
// serial routing between line, transmitter and receiver, with internal loop
`timescale 1ns/1ps
module loop_router (
  // clock and clear
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_clear,
  // loop select
  input  wire logic                     i_loop,
  // transmitter side and external line side
  input  wire sync_rx_csr_pkg::serial_t i_tx_ser,
  input  wire sync_rx_csr_pkg::serial_t i_line_rx,
  // outputs
  output logic                          o_line_txd,
  output sync_rx_csr_pkg::serial_t      o_rx_ser
);

  // line output: marking while looped so the far end sees idle
  always_ff @(posedge i_sys_clk) begin
    if (i_clear) begin
      o_line_txd <= 1'b1;
    end else if (i_loop) begin
      o_line_txd <= 1'b1;
    end else begin
      o_line_txd <= i_tx_ser.data;
    end
  end

  // receiver input and clock enable; both paths lag one cycle alike
  always_ff @(posedge i_sys_clk) begin
    if (i_clear) begin
      o_rx_ser <= '{data: 1'b1, clk_en: 1'b0};
    end else if (i_loop) begin
      o_rx_ser <= i_tx_ser;
    end else begin
      o_rx_ser <= i_line_rx;
    end
  end

endmodule

// File: src/sync_rx_csr.sv
// receive and transmit control/status register bank of the synchronous port
//
// Contract
// - bit 13 clear: primary station for bit-oriented protocols; set: secondary.
// - bit 13 clear: control station for byte-count protocol; set: tributary.
// - station-role bit is read/write, cleared by master reset or bus init.
// - bit 14 reads as the OR of all receiver error register flags.
// - the error summary setting clears the receive enable bit.
// - error summary setting with interrupt enable posts a receive interrupt.
// - error summary read-only; cleared by reset, init, or error register read.
// - bit 15 sets on complete message, even with characters still buffered.
// - done interrupt posts only after all buffered characters reach memory.
// - done flag read-only; cleared by writing the primary count field.
// - master reset or bus init sets the done flag to one.
// - loop clear: transmitter drives line, receiver takes line data.
// - loop set: transmitter output feeds the receiver input internally.
// - during loop the line output stays marking and line input ignored.
// - during loop the receiver uses the selected transmit clock.
// - loop bit is read/write, cleared by master reset or bus init.
// - sync_transmit_control_status decodes at byte offset six from the base.
// - sync_transmit_control_status takes word accesses only; read-modify-write allowed.
`timescale 1ns/1ps
module sync_rx_csr (
  // clock and resets
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_sys_rst,
  input  wire logic                      i_bus_init,
  // host register port
  input  wire sync_rx_csr_pkg::bus_req_t i_bus,
  output logic [15:0]                    o_bus_rdata,
  output logic                           o_bus_ack,
  // receive engine
  input  wire logic [7:0]                i_rx_err_set,
  input  wire logic                      i_msg_done,
  input  wire logic                      i_dma_empty,
  output logic                           o_rx_enable,
  output logic                           o_station_secondary,
  output logic                           o_rx_irq,
  output logic [13:0]                    o_pri_count,
  output logic                           o_pri_count_load,
  // transmit engine
  output logic [15:0]                    o_tx_csr,
  // serial paths
  input  wire sync_rx_csr_pkg::serial_t  i_tx_ser,
  input  wire sync_rx_csr_pkg::serial_t  i_line_rx,
  output logic                           o_line_txd,
  output sync_rx_csr_pkg::serial_t       o_rx_ser
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  // decode and write strobes
  logic        clear;
  logic [3:0]  word_addr;
  logic        hi_lane;
  logic [15:0] lane_mask;
  logic        hit_ind_sel;
  logic        hit_ind_data;
  logic        hit_rx_csr;
  logic        hit_tx_csr;
  logic        hit_count;
  logic        wr_rx_csr;
  logic        wr_tx_csr;
  logic        wr_count;
  logic        wr_ind_sel;
  logic        rd_err_clear;

  // stored register contents
  logic [15:0] rx_low_q;
  logic [15:0] rx_low_d;
  logic [15:0] tx_csr_q;
  logic [13:0] count_q;
  logic [3:0]  ind_sel_q;

  // completion and interrupt state
  logic        done_q;
  logic        done_pend_q;
  logic        done_irq;
  logic        err_irq;

  // receiver error register view
  logic [7:0]  err_q;
  logic        err_summary;
  logic        err_rise;

  // read path, interrupt and bus answer registers
  logic [15:0] rx_csr_view;
  logic [15:0] ind_view;
  logic [15:0] rdata_d;
  logic        rx_irq_q;
  logic [15:0] rdata_q;
  logic        ack_q;

  // master reset and bus initialize act alike on every flag
  assign clear = i_sys_rst | i_bus_init;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------

  // words sit on even offsets; odd byte address picks the upper lane
  assign word_addr = {i_bus.addr[3:1], 1'b0};
  assign hi_lane   = i_bus.addr[0];

  // a word access must be even; an odd word address matches nothing
  always_comb begin
    lane_mask = 16'h0000;
    if (i_bus.byte_acc) begin
      lane_mask = hi_lane ? 16'hFF00 : 16'h00FF;
    end else if (!hi_lane) begin
      lane_mask = 16'hFFFF;
    end
  end

  assign hit_ind_sel  = (word_addr == sync_rx_csr_pkg::OFS_IND_SEL);
  assign hit_ind_data = (word_addr == sync_rx_csr_pkg::OFS_IND_DATA);
  assign hit_rx_csr   = (word_addr == sync_rx_csr_pkg::OFS_RX_CSR);
  assign hit_count    = (word_addr == sync_rx_csr_pkg::OFS_PRI_COUNT);
  // byte accesses never reach the sync_transmit_control_status
  assign hit_tx_csr   = (i_bus.addr == sync_rx_csr_pkg::OFS_TX_CSR)
                        & ~i_bus.byte_acc;

  // write strobes, one per register
  assign wr_rx_csr  = i_bus.wr & hit_rx_csr & (lane_mask != 16'h0000);
  assign wr_tx_csr  = i_bus.wr & hit_tx_csr;
  assign wr_count   = i_bus.wr & hit_count & (lane_mask != 16'h0000);
  assign wr_ind_sel = i_bus.wr & hit_ind_sel & lane_mask[0];

  // a read that covers the low byte of the error register clears it
  assign rd_err_clear = i_bus.rd & hit_ind_data & lane_mask[0]
                        & (ind_sel_q == sync_rx_csr_pkg::IND_RX_ERR);

  // ---------------------------------------------------------------
  // receiver error register
  // ---------------------------------------------------------------
  // the bank keeps the flags; this level only decodes the read clear
  rx_error_bank u_err (
    .i_sys_clk      (i_sys_clk),
    .i_clear        (clear),
    .i_err_set      (i_rx_err_set),
    .i_rd_clear     (rd_err_clear),
    .o_err_q        (err_q),
    .o_summary      (err_summary),
    .o_summary_rise (err_rise)
  );

  // ---------------------------------------------------------------
  // sync_receive_control_status writable bits
  // ---------------------------------------------------------------

  // only role, loop and the low byte accept data; done and error
  // positions are masked out so software cannot disturb them
  always_comb begin
    rx_low_d = rx_low_q;
    if (wr_rx_csr) begin
      rx_low_d = (rx_low_q & ~(lane_mask & sync_rx_csr_pkg::RX_RW_MASK))
               | (i_bus.wdata & lane_mask & sync_rx_csr_pkg::RX_RW_MASK);
    end
    // hardware stop on error beats a simultaneous software enable
    if (err_rise) begin
      rx_low_d[sync_rx_csr_pkg::RX_EN_BIT] = 1'b0;
    end
  end

  // role and loop come back to zero on reset or init
  always_ff @(posedge i_sys_clk) begin
    if (clear) begin
      rx_low_q <= sync_rx_csr_pkg::RX_CSR_RST & sync_rx_csr_pkg::RX_RW_MASK;
    end else begin
      rx_low_q <= rx_low_d;
    end
  end

  // ---------------------------------------------------------------
  // primary receive done flag
  // ---------------------------------------------------------------

  // reset leaves the flag set; a message end in the same cycle as a
  // count write still leaves it set so no completion is lost
  always_ff @(posedge i_sys_clk) begin
    if (clear) begin
      done_q <= sync_rx_csr_pkg::RX_CSR_RST[sync_rx_csr_pkg::RX_DONE_PRI_BIT];
    end else if (i_msg_done) begin
      done_q <= 1'b1;
    end else if (wr_count) begin
      done_q <= 1'b0;
    end
  end

  // a finished message waits here until the buffer has drained
  always_ff @(posedge i_sys_clk) begin
    if (clear) begin
      done_pend_q <= 1'b0;
    end else if (i_msg_done) begin
      done_pend_q <= 1'b1;
    end else if (i_dma_empty) begin
      done_pend_q <= 1'b0;
    end
  end

  // interrupt requests; a pending message dropped with ie clear is lost
  assign done_irq = done_pend_q & ~i_msg_done & i_dma_empty
                    & rx_low_q[sync_rx_csr_pkg::RX_IE_BIT];
  assign err_irq  = err_rise & rx_low_q[sync_rx_csr_pkg::RX_IE_BIT];

  // one-cycle pulse toward the interrupt logic on the receive vector
  always_ff @(posedge i_sys_clk) begin
    if (clear) begin
      rx_irq_q <= 1'b0;
    end else begin
      rx_irq_q <= done_irq | err_irq;
    end
  end

  // ---------------------------------------------------------------
  // primary count, indirect select and sync_transmit_control_status
  // ---------------------------------------------------------------

  // count field; byte writes touch only their lane
  always_ff @(posedge i_sys_clk) begin
    if (clear) begin
      count_q <= sync_rx_csr_pkg::PRI_COUNT_RST;
    end else if (wr_count) begin
      count_q <= (count_q & ~lane_mask[13:0])
               | (i_bus.wdata[13:0] & lane_mask[13:0]);
    end
  end

  // one-cycle load strobe to the receive engine
  always_ff @(posedge i_sys_clk) begin
    if (clear) begin
      o_pri_count_load <= 1'b0;
    end else begin
      o_pri_count_load <= wr_count;
    end
  end

  // indirect index, low nibble of the select word
  always_ff @(posedge i_sys_clk) begin
    if (clear) begin
      ind_sel_q <= sync_rx_csr_pkg::IND_SEL_RST;
    end else if (wr_ind_sel) begin
      ind_sel_q <= i_bus.wdata[3:0];
    end
  end

  // whole word only; read then write back needs no lock here
  always_ff @(posedge i_sys_clk) begin
    if (clear) begin
      tx_csr_q <= sync_rx_csr_pkg::TX_CSR_RST;
    end else if (wr_tx_csr) begin
      tx_csr_q <= i_bus.wdata;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------

  // done, summary, then stored bits; unused bits read as zero
  always_comb begin
    rx_csr_view = rx_low_q;
    rx_csr_view[sync_rx_csr_pkg::RX_DONE_PRI_BIT] = done_q;
    rx_csr_view[sync_rx_csr_pkg::RX_ERR_BIT]      = err_summary;
  end

  // only the error register exists behind the indirect window
  always_comb begin
    ind_view = 16'h0000;
    if (ind_sel_q == sync_rx_csr_pkg::IND_RX_ERR) begin
      ind_view = {8'h00, err_q};
    end
  end

  // unmapped or refused reads answer zero rather than hang the bus
  always_comb begin
    rdata_d = 16'h0000;
    if (hit_rx_csr) begin
      rdata_d = rx_csr_view & lane_mask;
    end else if (hit_tx_csr) begin
      rdata_d = tx_csr_q;
    end else if (hit_count) begin
      rdata_d = {2'b00, count_q} & lane_mask;
    end else if (hit_ind_sel) begin
      rdata_d = {12'h000, ind_sel_q} & lane_mask;
    end else if (hit_ind_data) begin
      rdata_d = ind_view & lane_mask;
    end
  end

  // data is captured at the access edge and held until the next read
  always_ff @(posedge i_sys_clk) begin
    if (clear) begin
      rdata_q <= 16'h0000;
    end else if (i_bus.rd) begin
      rdata_q <= rdata_d;
    end
  end

  // every read or write is answered one cycle later
  always_ff @(posedge i_sys_clk) begin
    if (clear) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= i_bus.rd | i_bus.wr;
    end
  end

  // ---------------------------------------------------------------
  // serial routing
  // ---------------------------------------------------------------
  // mode switch applies at the next edge for data and clock alike
  loop_router u_loop (
    .i_sys_clk  (i_sys_clk),
    .i_clear    (clear),
    .i_loop     (rx_low_q[sync_rx_csr_pkg::RX_LOOP_BIT]),
    .i_tx_ser   (i_tx_ser),
    .i_line_rx  (i_line_rx),
    .o_line_txd (o_line_txd),
    .o_rx_ser   (o_rx_ser)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------

  // protocol engines read the role as a level
  assign o_station_secondary = rx_low_q[sync_rx_csr_pkg::RX_ROLE_BIT];

  // receive engine controls, all straight from flip-flops
  assign o_rx_enable         = rx_low_q[sync_rx_csr_pkg::RX_EN_BIT];
  assign o_rx_irq            = rx_irq_q;
  assign o_pri_count         = count_q;

  // register-side views toward the host and transmitter
  assign o_tx_csr            = tx_csr_q;
  assign o_bus_rdata         = rdata_q;
  assign o_bus_ack           = ack_q;

endmodule

// File: tb/line_partner.sv
// modem line model driving the external receive data and receive clock
`timescale 1ns/1ps
module line_partner (
  // clock and frame control
  input  wire logic                 i_clk,
  input  wire logic                 i_run,
  // line towards the device
  output sync_rx_csr_pkg::serial_t  o_line_rx
);
  // -----------------------------------------------------------------
  // line behaviour
  // -----------------------------------------------------------------
  logic [1:0] ph;

  initial begin
    ph        = 2'h0;
    o_line_rx = '0;
  end

  // receive clock stands still outside frames; idle data toggles so
  // a stale sample can never pass for a fresh one
  always @(negedge i_clk) begin
    ph                <= ph + 2'h1;
    o_line_rx.clk_en  <= i_run & ph[0];
    o_line_rx.data    <= i_run ? ph[1] : ~o_line_rx.data;
  end
endmodule

// File: tb/sync_rx_csr_properties.sv
// concurrent checks on the ports of the sync_receive_control_status bank
`timescale 1ns/1ps
module sync_rx_csr_properties (
  // clock and resets
  input wire logic                      i_sys_clk,
  input wire logic                      i_sys_rst,
  input wire logic                      i_bus_init,
  // watched ports
  input wire sync_rx_csr_pkg::bus_req_t i_bus,
  input wire logic [15:0]               o_bus_rdata,
  input wire logic                      o_bus_ack,
  input wire logic [7:0]                i_rx_err_set,
  input wire logic                      i_msg_done,
  input wire logic                      i_dma_empty,
  input wire logic                      o_rx_enable,
  input wire logic                      o_station_secondary,
  input wire logic                      o_rx_irq,
  input wire logic [13:0]               o_pri_count,
  input wire logic                      o_pri_count_load,
  input wire logic [15:0]               o_tx_csr,
  input wire sync_rx_csr_pkg::serial_t  i_tx_ser,
  input wire sync_rx_csr_pkg::serial_t  i_line_rx,
  input wire logic                      o_line_txd,
  input wire sync_rx_csr_pkg::serial_t  o_rx_ser
);
  // -----------------------------------------------------------------
  // properties
  // -----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst || i_bus_init);

  AST_ACK: assert property (!$past(i_sys_rst || i_bus_init) |->
    o_bus_ack == $past(i_bus.rd || i_bus.wr)) else $error("ack timing wrong");
  AST_RDATA_HELD: assert property (!$past(i_sys_rst || i_bus_init) && !$past(i_bus.rd)
    |-> $stable(o_bus_rdata)) else $error("read data moved without a read");
  AST_TX_WRITE: assert property (i_bus.wr && i_bus.addr == 4'h6 && !i_bus.byte_acc
    |=> o_tx_csr == $past(i_bus.wdata)) else $error("tx csr word write lost");
  AST_TX_REFUSE: assert property (i_bus.wr && !(i_bus.addr == 4'h6 && !i_bus.byte_acc)
    |=> $stable(o_tx_csr)) else $error("tx csr took a refused write");
  AST_COUNT_LOAD: assert property (i_bus.wr && i_bus.addr == 4'h8 && !i_bus.byte_acc
    |=> o_pri_count_load && o_pri_count == $past(i_bus.wdata[13:0]))
    else $error("count write not loaded");
  AST_ROLE_WRITE: assert property (!$past(i_sys_rst || i_bus_init)
    && $changed(o_station_secondary) |-> $past(i_bus.wr && i_bus.addr[3:1] == 3'h2))
    else $error("role moved alone");
  AST_ERR_STOPS_RX: assert property ($fell(o_rx_enable) && !$past(i_bus.wr)
    && !$past(i_sys_rst || i_bus_init)
    |-> ($past(i_rx_err_set) | $past(i_rx_err_set, 2) | $past(i_rx_err_set, 3)) != 8'h00)
    else $error("receive enable fell without cause");
  AST_IRQ_CAUSE: assert property (o_rx_irq |-> $past(i_dma_empty) ||
    ($past(i_rx_err_set, 2) | $past(i_rx_err_set, 3)) != 8'h00)
    else $error("receive interrupt without cause");
  AST_LINE_TXD: assert property (!o_line_txd |-> !$past(i_tx_ser.data))
    else $error("line data not from transmitter");
  AST_RX_PATH: assert property (!$past(i_sys_rst || i_bus_init) |->
    (o_rx_ser == $past(i_tx_ser) || o_rx_ser == $past(i_line_rx)))
    else $error("receiver input from nowhere");

  // main scenarios reached
  COV_IRQ: cover property (o_rx_irq);
  COV_LOAD: cover property (o_pri_count_load);
  COV_LOOP: cover property (o_line_txd && !$past(i_tx_ser.data));
endmodule

bind sync_rx_csr sync_rx_csr_properties u_props (
  .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_bus_init(i_bus_init),
  .i_bus(i_bus), .o_bus_rdata(o_bus_rdata), .o_bus_ack(o_bus_ack),
  .i_rx_err_set(i_rx_err_set), .i_msg_done(i_msg_done), .i_dma_empty(i_dma_empty),
  .o_rx_enable(o_rx_enable), .o_station_secondary(o_station_secondary),
  .o_rx_irq(o_rx_irq), .o_pri_count(o_pri_count), .o_pri_count_load(o_pri_count_load),
  .o_tx_csr(o_tx_csr), .i_tx_ser(i_tx_ser), .i_line_rx(i_line_rx),
  .o_line_txd(o_line_txd), .o_rx_ser(o_rx_ser));

// File: tb/sync_rx_csr_tb.sv
// self-checking bench for the sync_receive_control_status bank
`timescale 1ns/1ps
module sync_rx_csr_tb;
  // -----------------------------------------------------------------
  // signals and instances
  // -----------------------------------------------------------------
  logic                      clk, rst, init, mdone, dempty, run;
  sync_rx_csr_pkg::bus_req_t bus;
  logic [15:0]               rdata, txcsr, q;
  logic                      ack, rxen, sec, irq, cld, ltxd, seen;
  logic [7:0]                errs;
  logic [13:0]               cnt;
  sync_rx_csr_pkg::serial_t  txs, lrx, lrx_q, rxs;
  int                        miscompares, num_checks;

  sync_rx_csr dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_bus_init(init), .i_bus(bus),
    .o_bus_rdata(rdata), .o_bus_ack(ack), .i_rx_err_set(errs), .i_msg_done(mdone),
    .i_dma_empty(dempty), .o_rx_enable(rxen), .o_station_secondary(sec), .o_rx_irq(irq),
    .o_pri_count(cnt), .o_pri_count_load(cld), .o_tx_csr(txcsr), .i_tx_ser(txs),
    .i_line_rx(lrx), .o_line_txd(ltxd), .o_rx_ser(rxs));
  line_partner u_line (.i_clk(clk), .i_run(run), .o_line_rx(lrx));

  // line value the design sampled at the last rising edge
  always @(posedge clk) lrx_q <= lrx;

  // -----------------------------------------------------------------
  // shared tasks
  // -----------------------------------------------------------------
  task automatic chk16(input logic [15:0] g, input logic [15:0] e, input string m);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e, input string m);
    chk16({15'h0000, g}, {15'h0000, e}, m);
  endtask
  // one-cycle strobe; answer taken in the ack cycle
  task automatic acc(input logic [3:0] a, input logic r, input logic w, input logic b,
                     input logic [15:0] d, output logic [15:0] v);
    @(negedge clk);
    bus = '{addr: a, rd: r, wr: w, byte_acc: b, wdata: d};
    @(negedge clk);
    bus.rd = 1'b0;
    bus.wr = 1'b0;
    chk1(ack, 1'b1, "ack");
    v = rdata;
  endtask
  task automatic wr16(input logic [3:0] a, input logic [15:0] d);
    acc(a, 1'b0, 1'b1, 1'b0, d, q);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [15:0] e, input string m);
    acc(a, 1'b1, 1'b0, 1'b0, 16'h0000, q);
    chk16(q, e, m);
  endtask
  task automatic wait_irq(input int n);
    seen = 1'b0;
    repeat (n) begin
      @(negedge clk);
      if (irq === 1'b1) seen = 1'b1;
    end
  endtask

  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic t_reset_role();
    rdc(sync_rx_csr_pkg::OFS_RX_CSR, 16'h8000, "rx csr reset");
    rdc(sync_rx_csr_pkg::OFS_TX_CSR, 16'h0000, "tx csr reset");
    wr16(sync_rx_csr_pkg::OFS_RX_CSR, 16'h2000);
    chk1(sec, 1'b1, "secondary");
    rdc(sync_rx_csr_pkg::OFS_RX_CSR, 16'hA000, "role readback");
    wr16(sync_rx_csr_pkg::OFS_RX_CSR, 16'hFFFF);
    rdc(sync_rx_csr_pkg::OFS_RX_CSR, 16'hA1FF, "read-only bits");
    wr16(sync_rx_csr_pkg::OFS_RX_CSR, 16'h0050);
    chk1(sec, 1'b0, "primary");
    $display("test reset_role done");
  endtask

  // error pulse: enable falls, interrupt posted, read of error reg clears
  task automatic t_error();
    @(negedge clk) errs = 8'h04;
    @(negedge clk) errs = 8'h00;
    wait_irq(4);
    chk1(seen, 1'b1, "error irq");
    chk1(rxen, 1'b0, "rx stopped");
    wr16(sync_rx_csr_pkg::OFS_RX_CSR, 16'h0040);
    rdc(sync_rx_csr_pkg::OFS_RX_CSR, 16'hC040, "summary set");
    wr16(sync_rx_csr_pkg::OFS_IND_SEL, {12'h000, sync_rx_csr_pkg::IND_RX_ERR});
    rdc(sync_rx_csr_pkg::OFS_IND_DATA, 16'h0004, "error reg");
    rdc(sync_rx_csr_pkg::OFS_RX_CSR, 16'h8040, "summary cleared");
    $display("test error done");
  endtask

  // done flag sets with data still buffered; interrupt waits for drain
  task automatic t_done();
    dempty = 1'b0;
    wr16(sync_rx_csr_pkg::OFS_PRI_COUNT, 16'h3FFF);
    chk16({2'h0, cnt}, 16'h3FFF, "count");
    wr16(sync_rx_csr_pkg::OFS_RX_CSR, 16'hC040);
    rdc(sync_rx_csr_pkg::OFS_RX_CSR, 16'h0040, "done cleared");
    @(negedge clk) mdone = 1'b1;
    @(negedge clk) mdone = 1'b0;
    wait_irq(6);
    chk1(seen, 1'b0, "irq before drain");
    rdc(sync_rx_csr_pkg::OFS_RX_CSR, 16'h8040, "done set");
    dempty = 1'b1;
    wait_irq(3);
    chk1(seen, 1'b1, "irq after drain");
    $display("test done done");
  endtask

  // word, byte, odd, unmapped and read-modify-write cycles
  task automatic t_tx_csr();
    wr16(sync_rx_csr_pkg::OFS_TX_CSR, 16'h5AA5);
    rdc(sync_rx_csr_pkg::OFS_TX_CSR, 16'h5AA5, "tx word");
    acc(4'h6, 1'b0, 1'b1, 1'b1, 16'hFFFF, q);
    acc(4'h7, 1'b0, 1'b1, 1'b0, 16'hFFFF, q);
    acc(4'h6, 1'b1, 1'b0, 1'b1, 16'h0000, q);
    chk16(q, 16'h0000, "byte read");
    acc(4'hA, 1'b1, 1'b1, 1'b0, 16'hFFFF, q);
    chk16(q, 16'h0000, "unmapped");
    acc(4'h6, 1'b1, 1'b1, 1'b0, 16'hA55A, q);
    chk16(q, 16'h5AA5, "rmw old");
    chk16(txcsr, 16'hA55A, "rmw new");
    $display("test tx_csr done");
  endtask

  // external path, then internal loop with line held marking
  task automatic t_loop();
    run = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (i == 4) wr16(sync_rx_csr_pkg::OFS_RX_CSR, 16'h0100);
      @(negedge clk) txs = '{data: i[0], clk_en: ~i[1]};
      @(negedge clk);
      if (i < 4) begin
        chk1(ltxd, txs.data, "line txd");
        chk16({14'h0000, rxs}, {14'h0000, lrx_q}, "rx from line");
      end else begin
        chk1(ltxd, 1'b1, "marking");
        chk16({14'h0000, rxs}, {14'h0000, txs}, "rx looped");
      end
    end
    run = 1'b0;
    $display("test loop done");
  endtask

  // bus initialize in mid-run
  task automatic t_init();
    // space on the transmitter so a line left marking would show
    txs = '{data: 1'b0, clk_en: 1'b0};
    wr16(sync_rx_csr_pkg::OFS_RX_CSR, 16'h2100);
    @(negedge clk) init = 1'b1;
    @(negedge clk) init = 1'b0;
    rdc(sync_rx_csr_pkg::OFS_RX_CSR, 16'h8000, "after init");
    chk1(ltxd, txs.data, "line after init");
    $display("test init done");
  endtask

  // -----------------------------------------------------------------
  // run control
  // -----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // whole sequence is under a hundred cycles
  initial begin
    #100us;
    miscompares++;
    complete_run();
  end

  initial begin
    miscompares = 0;
    num_checks  = 0;
    rst = 1'b1;
    init = 1'b0;
    bus = '0;
    errs = 8'h00;
    mdone = 1'b0;
    dempty = 1'b1;
    run = 1'b0;
    txs = '{data: 1'b1, clk_en: 1'b0};
    repeat (2) @(negedge clk);
    rst = 1'b0;
    t_reset_role();
    t_error();
    t_done();
    t_tx_csr();
    t_loop();
    t_init();
    complete_run();
  end
endmodule
